// ### rtl/hai_pkg.sv
// Shared constants and types for the hardware alert interface.
// Functional notes
// RULE1 - topology code 10 swaps to differential alert
// RULE2 - default alert path single-ended, one direction
// RULE3 - SPI output active low, open-drain or CMOS
// RULE4 - UART alert is 2MHz 50% square wave
// RULE5 - UART idle: low, or high-Z when selected
// RULE6 - differential topology keeps pin at idle level; DC test mode still drives the pin from the alert
// RULE7 - wave lasts with fault, refreshed per scan
// RULE8 - incoming alert accepted after 25us valid wave
// RULE9 - disabled alert: no pin activity, input ignored; DC test mode still drives the pin from the alert
// RULE10 - SPI mode ignores the alert input pin
// RULE11 - alert is OR of masked flags plus POR
// RULE12 - masking never hides the raw status flags
// RULE13 - packet summary layout, bits 15 and 6 zero
// RULE14 - scan flag drives pin, not packet summary
// RULE15 - balance masking only when top selects equal
// RULE16 - DC test drives low on alert, else high
// RULE17 - forced alert drives pin without real fault
// RULE18 - wave and qualifier timed from core clock
package hai_pkg;

   // ----------------------------------------
   // Clock and timing
   // ----------------------------------------
   localparam int CLK_MHZ = 200;
   localparam int WAVE_HALF_NS = 250;
   localparam int WAVE_HALF_CYC = (WAVE_HALF_NS * CLK_MHZ) / 1000;
   localparam logic [5:0] WAVE_HALF_LAST = 6'(WAVE_HALF_CYC - 1);
   // Accepted half-period window of an incoming wave
   localparam int HALF_MIN_NS = 200;
   localparam int HALF_MAX_NS = 300;
   localparam logic [6:0] HALF_MIN_CYC = 7'((HALF_MIN_NS * CLK_MHZ + 999) / 1000);
   localparam logic [6:0] HALF_MAX_CYC = 7'((HALF_MAX_NS * CLK_MHZ) / 1000);
   localparam logic [6:0] HALF_SAT = 7'h7f;
   localparam int QUAL_US = 25;
   localparam int QUAL_CYC = QUAL_US * CLK_MHZ;

   // ----------------------------------------
   // Status layout
   // ----------------------------------------
   localparam int BIT_SCAN = 15;
   localparam int BIT_POR = 14;
   localparam int BIT_SPARE = 6;
   localparam int BIT_DIAG2 = 0;
   localparam int NUM_BAL = 14;
   localparam int TOP_W = 4;
   localparam logic [15:0] SUMMARY_RST = 16'h0000;
   localparam logic [15:0] STATUS_RST = 16'h0000;

   // ----------------------------------------
   // Types
   // ----------------------------------------
   typedef enum logic [1:0] {
      TOPO_EXT_LOOP = 2'b00,
      TOPO_INT_LOOP = 2'b01,
      TOPO_DIFF = 2'b10,
      TOPO_DUAL = 2'b11
   } hai_topo_t;

   typedef enum logic [2:0] {
      DRV_IDLE = 3'b000,
      DRV_SPI = 3'b001,
      DRV_WAVE = 3'b010,
      DRV_DC = 3'b011
   } hai_drive_t;

   typedef struct packed {
      logic hostPortSelect;
      hai_topo_t linkTopologySelect;
      logic hwAlertEnable;
      logic spiAlertDriveType;
      logic idleTristateSelect;
      logic alertDcTestEnable;
      logic forcedAlertDrive;
   } hai_cfg_t;

endpackage

// ### rtl/hai_alert_qual.sv
// Qualifier for the alert wave arriving from the neighbouring device.
`timescale 1ns/10ps
module hai_alert_qual import hai_pkg::*; #(
   parameter int QUAL_CYCLES = QUAL_CYC
) (
   input wire logic core_clk,
   input wire logic rst,
   input wire logic listen,
   input wire logic alertChainInput,
   output logic chainAlertValid
);

   logic sync1;
   logic sync2;
   logic sync3;
   logic lvl;
   logic [6:0] halfCnt;
   logic [15:0] runCnt;

   localparam logic [15:0] QUAL_LIM = 16'(QUAL_CYCLES);

   // A change counts only once the second and third stages agree
   wire logic lvlEdge = (sync2 == sync3) && (sync3 != lvl);
   wire logic goodHalf = (halfCnt >= HALF_MIN_CYC) && (halfCnt <= HALF_MAX_CYC);
   wire logic [16:0] sum = {1'b0, runCnt} + {10'h000, halfCnt} + 17'h0_0001;
   wire logic [15:0] next_runCnt = (sum >= {1'b0, QUAL_LIM}) ? QUAL_LIM : sum[15:0];

   always_ff @(posedge core_clk) begin
      sync1 <= alertChainInput;
      sync2 <= sync1;
      sync3 <= sync2;
   end

   // ----------------------------------------
   // Half-period measurement
   // ----------------------------------------
   // RULE8 accumulate valid time
   always_ff @(posedge core_clk) begin
      if (rst) begin
         lvl <= 1'b0;
         halfCnt <= HALF_SAT;
         runCnt <= 16'h0000;
         chainAlertValid <= 1'b0;
      end else if (!listen) begin
         // RULE9 deaf while disabled
         lvl <= sync3;
         halfCnt <= HALF_SAT;
         runCnt <= 16'h0000;
         chainAlertValid <= 1'b0;
      end else begin
         if (sync2 == sync3) begin
            lvl <= sync3;
         end
         if (lvlEdge) begin
            halfCnt <= 7'h00;
            runCnt <= goodHalf ? next_runCnt : 16'h0000;
         end else begin
            if (halfCnt > HALF_MAX_CYC) begin
               runCnt <= 16'h0000;
            end
            if (halfCnt != HALF_SAT) begin
               halfCnt <= halfCnt + 7'h01;
            end
         end
         chainAlertValid <= (runCnt >= QUAL_LIM);
      end
   end

   // ----------------------------------------
   // Checks
   // ----------------------------------------
   property p_quietWhenDeaf;
      @(posedge core_clk) disable iff (rst) !listen |=> !chainAlertValid;
   endproperty
   a_quietWhenDeaf: assert property (p_quietWhenDeaf) // RULE9
      else $error("chain alert valid while not listening");

   property p_qualMinTime;
      @(posedge core_clk) disable iff (rst)
         $rose(chainAlertValid) |-> $past(runCnt) >= QUAL_LIM;
   endproperty
   a_qualMinTime: assert property (p_qualMinTime) // RULE8
      else $error("chain alert accepted before qualify time");

   property p_dropOnSilence;
      @(posedge core_clk) disable iff (rst)
         (listen && halfCnt > HALF_MAX_CYC && !lvlEdge) ##1 listen |=> !chainAlertValid;
   endproperty
   a_dropOnSilence: assert property (p_dropOnSilence) // RULE8
      else $error("chain alert kept after wave stopped");

   c_accepted: cover property (@(posedge core_clk) disable iff (rst) $rose(chainAlertValid));

endmodule

// ### rtl/hai_alert_top.sv
// Alert condition, packet summary and alert pin driver.
`timescale 1ns/10ps
module hai_alert_top import hai_pkg::*; #(
   parameter int QUAL_CYCLES = QUAL_CYC
) (
   input wire logic core_clk,
   input wire logic rst,
   input wire hai_cfg_t cfg,
   input wire logic [15:0] primaryFaultStatus,
   input wire logic [15:0] alertMaskRegister,
   input wire logic [NUM_BAL-1:0] balanceSwitchFault,
   input wire logic [TOP_W-1:0] topInputSelectA,
   input wire logic [TOP_W-1:0] topInputSelectB,
   input wire logic scanUpdate,
   input wire logic alertChainInput,
   output logic alertChainOutput,
   output logic alertChainOutputEn,
   output logic diffAlertOut,
   output logic [15:0] packetFaultSummary,
   output logic [15:0] faultStatusView,
   output logic alertPending
);

   // ----------------------------------------
   // Balance-switch masking
   // ----------------------------------------
   logic [NUM_BAL-1:0] balReported;
   wire logic topMatch = (topInputSelectA == topInputSelectB);

   // RULE15 mask unused switches
   genvar gi;
   generate
      for (gi = 0; gi < NUM_BAL; gi = gi + 1) begin : g_bal
         assign balReported[gi] = balanceSwitchFault[gi] &
            ~(topMatch & (TOP_W'(gi) >= topInputSelectA));
      end
   endgenerate

   // ----------------------------------------
   // Masked status and alert condition
   // ----------------------------------------
   logic [15:0] effStatus;
   logic [15:0] maskedStatus;
   logic [15:0] next_summary;
   logic localAlert;

   // RULE12 raw flags stay visible
   assign effStatus = {primaryFaultStatus[15:1],
      primaryFaultStatus[BIT_DIAG2] | (|balReported)};
   assign maskedStatus = effStatus & alertMaskRegister;

   // RULE11 OR of masked flags
   // RULE14 scan flag feeds the pin
   assign localAlert = maskedStatus[BIT_SCAN] | effStatus[BIT_POR] |
      (|maskedStatus[13:7]) | (|maskedStatus[5:0]);

   // RULE13 packet summary layout
   // RULE14 scan flag left out
   assign next_summary = {1'b0, effStatus[BIT_POR], maskedStatus[13:7], 1'b0,
      maskedStatus[5:0]};

   // ----------------------------------------
   // Mode decode
   // ----------------------------------------
   wire logic isUart = cfg.hostPortSelect;
   // RULE1 topology selects scheme
   wire logic diffTopo = (cfg.linkTopologySelect == TOPO_DIFF);
   // RULE2 single-ended receive path
   // RULE10 SPI mode ignores input
   wire logic chainListen = isUart & cfg.hwAlertEnable & ~diffTopo;

   logic chainValid;
   logic alertState;

   hai_alert_qual #(
      .QUAL_CYCLES(QUAL_CYCLES)
   ) u_qual (
      .core_clk(core_clk),
      .rst(rst),
      .listen(chainListen),
      .alertChainInput(alertChainInput),
      .chainAlertValid(chainValid)
   );

   // RULE17 forced drive counts as alert
   wire logic alertCond = alertState | chainValid | cfg.forcedAlertDrive;
   // RULE9 alert kept off the pins when disabled, except in DC test mode
   wire logic alertAsserted = alertCond & cfg.hwAlertEnable;

   // In UART mode test mode has priority so the pin can be exercised in every topology
   hai_drive_t driveMode;
   assign driveMode = (isUart & cfg.alertDcTestEnable) ? DRV_DC :
      (!isUart) ? DRV_SPI :
      diffTopo ? DRV_IDLE :
      alertAsserted ? DRV_WAVE : DRV_IDLE;

   // ----------------------------------------
   // Square wave generator
   // ----------------------------------------
   logic [5:0] phaseCnt;
   logic wavePhase;
   wire logic waveOn = (driveMode == DRV_WAVE);
   wire logic halfDone = (phaseCnt == WAVE_HALF_LAST);

   // RULE18 divide core clock to 2MHz
   always_ff @(posedge core_clk) begin
      if (rst || !waveOn) begin
         phaseCnt <= 6'h00;
         wavePhase <= 1'b1;
      end else if (halfDone) begin
         phaseCnt <= 6'h00;
         wavePhase <= ~wavePhase;
      end else begin
         phaseCnt <= phaseCnt + 6'h01;
      end
   end

   // ----------------------------------------
   // Pin level selection
   // ----------------------------------------
   logic next_out;
   logic next_outEn;

   always_comb begin
      next_out = 1'b0;
      next_outEn = 1'b0;
      case (driveMode)
         DRV_DC: begin
            // RULE16 low on alert, else high
            next_out = ~alertCond;
            next_outEn = 1'b1;
         end
         DRV_SPI: begin
            // RULE3 open-drain or CMOS
            next_out = cfg.spiAlertDriveType & ~alertAsserted;
            next_outEn = cfg.spiAlertDriveType | alertAsserted;
         end
         DRV_WAVE: begin
            // RULE4 square wave while alert
            next_out = wavePhase;
            next_outEn = 1'b1;
         end
         default: begin
            // RULE5 idle level
            // RULE6 idle in differential mode
            next_out = 1'b0;
            next_outEn = ~cfg.idleTristateSelect;
         end
      endcase
   end

   // ----------------------------------------
   // Registers
   // ----------------------------------------
   // RULE7 state refreshed per scan
   always_ff @(posedge core_clk) begin
      if (rst) begin
         alertState <= 1'b0;
         packetFaultSummary <= SUMMARY_RST;
      end else if (scanUpdate) begin
         alertState <= localAlert;
         packetFaultSummary <= next_summary;
      end
   end

   always_ff @(posedge core_clk) begin
      if (rst) begin
         alertChainOutput <= 1'b0;
         alertChainOutputEn <= 1'b0;
         diffAlertOut <= 1'b0;
         faultStatusView <= STATUS_RST;
         alertPending <= 1'b0;
      end else begin
         alertChainOutput <= next_out;
         alertChainOutputEn <= next_outEn;
         // RULE6 alert carried on down path
         diffAlertOut <= isUart & diffTopo & alertAsserted;
         faultStatusView <= effStatus;
         alertPending <= alertCond;
      end
   end

   // ----------------------------------------
   // Checks
   // ----------------------------------------
   property p_spiAssert;
      @(posedge core_clk) disable iff (rst)
         (!isUart && alertAsserted) |=> (!alertChainOutput && alertChainOutputEn);
   endproperty
   a_spiAssert: assert property (p_spiAssert) // RULE3
      else $error("SPI alert not driven low");

   property p_spiIdle;
      @(posedge core_clk) disable iff (rst)
         (!isUart && !alertAsserted) |=>
            (alertChainOutputEn == $past(cfg.spiAlertDriveType)) &&
            (alertChainOutput == $past(cfg.spiAlertDriveType));
   endproperty
   a_spiIdle: assert property (p_spiIdle) // RULE3
      else $error("SPI idle level wrong");

   property p_waveToggle;
      @(posedge core_clk) disable iff (rst)
         (waveOn && halfDone) ##1 waveOn |=> alertChainOutput != $past(alertChainOutput);
   endproperty
   a_waveToggle: assert property (p_waveToggle) // RULE4
      else $error("alert wave did not toggle on half period");

   property p_waveHold;
      @(posedge core_clk) disable iff (rst)
         (waveOn && phaseCnt == 6'h00) ##1 waveOn |=> $stable(alertChainOutput);
   endproperty
   a_waveHold: assert property (p_waveHold) // RULE4
      else $error("alert wave toggled early");

   property p_uartIdle;
      @(posedge core_clk) disable iff (rst)
         (isUart && !cfg.alertDcTestEnable && !alertAsserted) |=>
            !alertChainOutput && (alertChainOutputEn == !$past(cfg.idleTristateSelect));
   endproperty
   a_uartIdle: assert property (p_uartIdle) // RULE5
      else $error("UART idle level wrong");

   property p_diffIdle;
      @(posedge core_clk) disable iff (rst)
         (isUart && diffTopo && !cfg.alertDcTestEnable) |=>
            !alertChainOutput && (alertChainOutputEn == !$past(cfg.idleTristateSelect));
   endproperty
   a_diffIdle: assert property (p_diffIdle) // RULE6
      else $error("pin active in differential topology");

   property p_dcTest;
      @(posedge core_clk) disable iff (rst)
         (isUart && cfg.alertDcTestEnable) |=>
            alertChainOutputEn && (alertChainOutput == !$past(alertCond));
   endproperty
   a_dcTest: assert property (p_dcTest) // RULE16
      else $error("DC test level wrong");

   property p_porUnmasked;
      @(posedge core_clk) disable iff (rst)
         (scanUpdate && effStatus[BIT_POR]) |=> alertState ##1 alertPending;
   endproperty
   a_porUnmasked: assert property (p_porUnmasked) // RULE11
      else $error("POR flag did not raise alert");

   property p_summaryFixed;
      @(posedge core_clk) disable iff (rst)
         scanUpdate |=> !packetFaultSummary[15] && !packetFaultSummary[BIT_SPARE] &&
            (packetFaultSummary[BIT_POR] == $past(primaryFaultStatus[BIT_POR]));
   endproperty
   a_summaryFixed: assert property (p_summaryFixed) // RULE13
      else $error("packet summary fixed bits wrong");

   property p_spiDeaf;
      @(posedge core_clk) disable iff (rst) !isUart ##1 !isUart |-> !chainValid;
   endproperty
   a_spiDeaf: assert property (p_spiDeaf) // RULE10
      else $error("chain alert accepted in SPI mode");

   property p_scanToPin;
      @(posedge core_clk) disable iff (rst)
         (scanUpdate && primaryFaultStatus[BIT_SCAN] && alertMaskRegister[BIT_SCAN]) |=>
            alertState && !packetFaultSummary[BIT_SCAN];
   endproperty
   a_scanToPin: assert property (p_scanToPin) // RULE14
      else $error("scan flag did not reach alert or leaked into summary");

   property p_forcedDrive;
      @(posedge core_clk) disable iff (rst)
         (!isUart && cfg.hwAlertEnable && cfg.forcedAlertDrive) |=>
            !alertChainOutput && alertChainOutputEn;
   endproperty
   a_forcedDrive: assert property (p_forcedDrive) // RULE17
      else $error("forced alert not driven on pin");

   property p_viewRaw;
      @(posedge core_clk) disable iff (rst)
         1'b1 |=> (faultStatusView[15:1] == $past(primaryFaultStatus[15:1])) &&
            (faultStatusView[BIT_DIAG2] || !$past(primaryFaultStatus[BIT_DIAG2]));
   endproperty
   a_viewRaw: assert property (p_viewRaw) // RULE12
      else $error("raw status hidden by masking");

   property p_balReport;
      @(posedge core_clk) disable iff (rst)
         (!topMatch && (|balanceSwitchFault)) |=> faultStatusView[BIT_DIAG2];
   endproperty
   a_balReport: assert property (p_balReport) // RULE15
      else $error("balance fault masked with unequal top selects");

   property p_diffCarry;
      @(posedge core_clk) disable iff (rst)
         (isUart && diffTopo && alertAsserted) |=> diffAlertOut;
   endproperty
   a_diffCarry: assert property (p_diffCarry) // RULE6
      else $error("alert missing on down path");

   property p_diffOff;
      @(posedge core_clk) disable iff (rst)
         !(isUart && diffTopo) |=> !diffAlertOut;
   endproperty
   a_diffOff: assert property (p_diffOff) // RULE1
      else $error("down path alert outside differential topology");

   property p_chainFwd;
      @(posedge core_clk) disable iff (rst)
         (chainValid && isUart && !diffTopo && !cfg.alertDcTestEnable && cfg.hwAlertEnable)
            |=> alertChainOutputEn && alertPending;
   endproperty
   a_chainFwd: assert property (p_chainFwd) // RULE2
      else $error("accepted chain alert not forwarded");

   c_dcTest: cover property (@(posedge core_clk) disable iff (rst)
      isUart && cfg.alertDcTestEnable);
   c_wave: cover property (@(posedge core_clk) disable iff (rst) waveOn && halfDone);
   c_spiAlert: cover property (@(posedge core_clk) disable iff (rst)
      !isUart && alertAsserted);
   c_balMasked: cover property (@(posedge core_clk) disable iff (rst)
      topMatch && (balanceSwitchFault != balReported));

endmodule

// ### sim/hai_chain_sender.sv
// Upstream neighbour model that sends alert bursts into the chain input.
`timescale 1ns/10ps
module hai_chain_sender (
   output logic line
);
   // ----------------------------------------
   // Burst driver
   // ----------------------------------------
   // The link idles low between bursts, so no stale level is left behind
   initial line = 1'b0;

   task automatic send(input int halfNs, input int halves);
      for (int i = 0; i < halves; i++) begin
         line = ~line;
         #(halfNs);
      end
      line = 1'b0;
   endtask
endmodule

// ### sim/hai_alert_top_bench.sv
// Self-checking bench for the hardware alert block.
`timescale 1ns/10ps
module hai_alert_top_bench import hai_pkg::*; ();
   // ----------------------------------------
   // Signals and queue of expected results
   // ----------------------------------------
   localparam int QC = 400;
   localparam int LIMIT = 30000;
   typedef struct {
      int sel;
      logic [15:0] val;
   } hai_note_t;
   logic core_clk = 1'b0;
   logic rst = 1'b1;
   hai_cfg_t cfg;
   logic [15:0] st, msk, m, summary, view, seen;
   logic [NUM_BAL-1:0] bal;
   logic [TOP_W-1:0] topA, topB;
   logic scan, chainIn, pinOut, pinEn, diffOut, pending;
   hai_note_t notes[$];
   hai_note_t n;
   hai_topo_t topo;
   event chk;
   int mismatches = 0;
   int samplesChecked = 0;
   int cycles = 0;

   always #2.5 core_clk = ~core_clk;

   hai_chain_sender sender (.line(chainIn));

   hai_alert_top #(.QUAL_CYCLES(QC)) i_dut (
      .core_clk(core_clk), .rst(rst), .cfg(cfg), .primaryFaultStatus(st),
      .alertMaskRegister(msk), .balanceSwitchFault(bal), .topInputSelectA(topA),
      .topInputSelectB(topB), .scanUpdate(scan), .alertChainInput(chainIn),
      .alertChainOutput(pinOut), .alertChainOutputEn(pinEn), .diffAlertOut(diffOut),
      .packetFaultSummary(summary), .faultStatusView(view), .alertPending(pending)
   );

   // ----------------------------------------
   // Helpers
   // ----------------------------------------
   function automatic hai_cfg_t mk(int h, hai_topo_t t, int e, int v, int z, int d, int f);
      return '{1'(h), t, 1'(e), 1'(v), 1'(z), 1'(d), 1'(f)};
   endfunction

   task automatic check(input logic [15:0] got, input logic [15:0] want);
      samplesChecked++;
      if (got !== want) begin
         mismatches++;
         $display("BAD t=%0t seen=%h want=%h", $time, got, want);
      end
   endtask

   task automatic note(input int sel, input logic [15:0] val);
      notes.push_back('{sel, val});
      ->chk;
   endtask

   task automatic finish_test();
      $display("checked %0d mismatched %0d", samplesChecked, mismatches);
      if (mismatches == 0 && samplesChecked > 0) begin
         $display("NO MISMATCHES");
      end else begin
         $display("MISMATCHES SEEN");
      end
      $finish;
   endtask

   // Alert state only moves on a scan pulse, then two edges to the pin
   task automatic scanPulse();
      scan = 1'b1;
      @(negedge core_clk);
      scan = 1'b0;
      repeat (2) @(negedge core_clk);
   endtask

   // Pin word is {enable, driven level}; a released pin reads as 00
   task automatic pin(input hai_cfg_t c, input logic a, input logic [1:0] e, input logic d);
      cfg = c;
      st = a ? 16'h0008 : 16'h0000;
      msk = 16'h0008;
      scanPulse();
      note(0, {14'h0000, e});
      note(4, {15'h0000, d});
   endtask

   task automatic balT(input int a, input int b, input int idx, input logic e);
      topA = 4'(a);
      topB = 4'(b);
      bal = NUM_BAL'(1) << idx;
      scanPulse();
      note(2, {15'h0000, e});
      note(0, {14'h0000, 1'b1, ~e});
   endtask

   task automatic chain(input hai_cfg_t c, input int halfNs, input int cnt, input logic e);
      cfg = c;
      st = 16'h0000;
      scanPulse();
      sender.send(halfNs, cnt);
      repeat (4) @(negedge core_clk);
      note(3, {15'h0000, e});
      repeat (300) @(negedge core_clk);
   endtask

   // ----------------------------------------
   // Monitor: compares outputs against the oldest note
   // ----------------------------------------
   always @(chk) begin
      while (notes.size() > 0) begin
         n = notes.pop_front();
         case (n.sel)
            0: seen = {14'h0000, pinEn, pinEn & pinOut};
            1: seen = summary;
            2: seen = view;
            3: seen = {15'h0000, pending};
            default: seen = {15'h0000, diffOut};
         endcase
         check(seen, n.val);
      end
   end

   always @(posedge core_clk) begin
      cycles <= cycles + 1;
      if (cycles == LIMIT) begin
         mismatches++;
         finish_test();
      end
   end

   // ----------------------------------------
   // Tests
   // ----------------------------------------
   initial begin
      void'($urandom(32'h8047));
      cfg = mk(0, TOPO_EXT_LOOP, 0, 0, 0, 0, 0);
      st = 16'h0000;
      msk = 16'h0000;
      bal = '0;
      topA = 4'h0;
      topB = 4'h0;
      scan = 1'b0;
      repeat (10) @(negedge core_clk);
      note(0, 16'h0000);
      note(1, SUMMARY_RST);
      rst = 1'b0;
      $display("test reset done");
      for (int i = 0; i < 8; i++) begin
         st = 16'($urandom());
         msk = 16'($urandom());
         if (i < 2) begin
            st = i ? 16'hbfbf : 16'h8000;
            msk = i ? 16'h0000 : 16'h8000;
         end
         st[6] = 1'b0;
         cfg = mk(0, TOPO_EXT_LOOP, 1, 1, 0, 0, 0);
         scanPulse();
         m = st & msk;
         note(1, {1'b0, st[14], m[13:7], 1'b0, m[5:0]});
         note(2, st);
         note(0, {14'h0000, 1'b1, ~((|(m & 16'hbfbf)) | st[14])});
      end
      $display("test summary done");
      pin(mk(0, TOPO_EXT_LOOP, 1, 0, 0, 0, 0), 1, 2'h2, 0);
      pin(mk(0, TOPO_EXT_LOOP, 1, 0, 0, 0, 0), 0, 2'h0, 0);
      pin(mk(0, TOPO_EXT_LOOP, 1, 1, 0, 0, 0), 0, 2'h3, 0);
      pin(mk(1, TOPO_EXT_LOOP, 1, 0, 0, 0, 0), 0, 2'h2, 0);
      pin(mk(1, TOPO_EXT_LOOP, 1, 0, 1, 0, 0), 0, 2'h0, 0);
      pin(mk(1, TOPO_DIFF, 1, 0, 0, 0, 0), 1, 2'h2, 1);
      pin(mk(1, TOPO_DIFF, 1, 0, 1, 0, 0), 1, 2'h0, 1);
      pin(mk(1, TOPO_DIFF, 1, 0, 0, 1, 0), 1, 2'h2, 1);
      pin(mk(1, TOPO_DIFF, 1, 0, 0, 1, 0), 0, 2'h3, 0);
      pin(mk(1, TOPO_EXT_LOOP, 0, 0, 0, 0, 0), 1, 2'h2, 0);
      pin(mk(0, TOPO_EXT_LOOP, 0, 1, 0, 0, 0), 1, 2'h3, 0);
      pin(mk(0, TOPO_EXT_LOOP, 1, 1, 0, 0, 1), 0, 2'h2, 0);
      $display("test drive done");
      for (int k = 0; k < 3; k++) begin
         topo = hai_topo_t'((k == 2) ? 0 : 2 * k + 1);
         pin(mk(1, topo, 1, 0, 1, 0, 0), 0, 2'h0, 0);
         pin(mk(1, topo, 1, 0, 1, 0, 0), 1, 2'h3, 0);
      end
      repeat (50) @(negedge core_clk);
      note(0, 16'h0002);
      repeat (50) @(negedge core_clk);
      note(0, 16'h0003);
      pin(mk(1, TOPO_EXT_LOOP, 1, 0, 0, 0, 0), 0, 2'h2, 0);
      $display("test wave done");
      cfg = mk(0, TOPO_EXT_LOOP, 1, 1, 0, 0, 0);
      msk = 16'h0001;
      st = 16'h0000;
      balT(5, 5, 5, 0);
      balT(5, 5, 4, 1);
      balT(5, 6, 13, 1);
      bal = '0;
      $display("test balance done");
      chain(mk(1, TOPO_EXT_LOOP, 1, 0, 0, 0, 0), 250, 20, 1);
      chain(mk(1, TOPO_EXT_LOOP, 1, 0, 0, 0, 0), 290, 16, 1);
      chain(mk(1, TOPO_EXT_LOOP, 1, 0, 0, 0, 0), 250, 6, 0);
      chain(mk(1, TOPO_EXT_LOOP, 1, 0, 0, 0, 0), 400, 12, 0);
      chain(mk(1, TOPO_EXT_LOOP, 1, 0, 0, 0, 0), 150, 24, 0);
      chain(mk(0, TOPO_EXT_LOOP, 1, 0, 0, 0, 0), 250, 20, 0);
      chain(mk(1, TOPO_EXT_LOOP, 0, 0, 0, 0, 0), 250, 20, 0);
      chain(mk(1, TOPO_DIFF, 1, 0, 0, 0, 0), 250, 20, 0);
      $display("test chain done");
      repeat (2) @(negedge core_clk);
      finish_test();
   end
endmodule
